// ### logic/tas_pkg.sv
// Package for the alert status flag block: offsets, bit positions, widths.
// Assumes a register access front end that presents decoded read strobes.
package tas_pkg;
    localparam logic [7:0] TAS_ADDR_TEMP = 8'h00;
    localparam logic [7:0] TAS_ADDR_STATUS = 8'h02;
    localparam int TAS_REG_W = 16;
    localparam logic [15:0] TAS_STATUS_RESET = 16'h0000;
    localparam int TAS_BIT_CRC = 7;
    localparam int TAS_BIT_SLEW_ST = 6;
    localparam int TAS_BIT_SLEW_FL = 5;
    localparam int TAS_BIT_HIGH_ST = 4;
    localparam int TAS_BIT_LOW_ST = 3;
    localparam int TAS_BIT_HIGH_FL = 2;
    localparam int TAS_BIT_LOW_FL = 1;
    localparam int TAS_BIT_DRDY = 0;
    localparam int TAS_TEMP_W = 14;
    localparam int TAS_EN_W = 5;
    localparam int TAS_EN_CRC = 4;
    localparam int TAS_EN_SLEW = 3;
    localparam int TAS_EN_HIGH = 2;
    localparam int TAS_EN_LOW = 1;
    localparam int TAS_EN_DRDY = 0;
endpackage

// ### logic/tas_alert_status.sv
// Alert status register: sticky flags, live threshold status, alert pin.
// Assumes conversion results, limits and serial-access strobes come from
// neighbouring logic synchronous to mclk, each strobe one cycle long.
// Notes on behaviour
// - Status read-to-clear happens only on single-register reads; a burst temperature read still clears bit 0.
// - Bit 7 latches a checksum write failure; reads 0 after a good write.
// - Bit 6 is live: last conversion slew positive and above slew limit.
// - Bit 5 is sticky slew flag, set on limit crossing, cleared by read.
// - Bit 4 live high status with hysteresis release below limit minus hyst.
// - Bit 3 live low status with hysteresis release above limit plus hyst.
// - Bit 2 sticky high flag on crossing above limit or below hysteresis.
// - Upward high crossing rearms only after dropping below limit minus hyst.
// - Bit 1 sticky low flag on crossing below limit or above hysteresis.
// - Downward low crossing rearms only after rising above limit plus hyst.
// - Bit 0 marks unread result; cleared reading status or temperature.
// - Register is 16 bits, resets to zero, upper byte reserved.
// - In interrupt mode, alert pin low when an enabled flag is set; flags record regardless.
// - Interrupt mode uses sticky flags; comparator mode uses live high and slew status only.
`timescale 1ns/1ps
`default_nettype none

module tas_alert_status #(
    parameter int TEMP_W = tas_pkg::TAS_TEMP_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Conversion results
    input wire logic conv_done,
    input wire logic signed [TEMP_W-1:0] temp_value,
    input wire logic signed [TEMP_W-1:0] slew_value,
    // Limits from the limit registers
    input wire logic signed [TEMP_W-1:0] high_limit,
    input wire logic signed [TEMP_W-1:0] low_limit,
    input wire logic [TEMP_W-1:0] high_hyst,
    input wire logic [TEMP_W-1:0] low_hyst,
    input wire logic signed [TEMP_W-1:0] slew_limit,
    // Checksum-protected write outcome
    input wire logic crc_write_done,
    input wire logic crc_write_ok,
    // Register access from serial front end
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic reg_burst,
    // Alert configuration
    input wire logic [tas_pkg::TAS_EN_W-1:0] alert_enable,
    input wire logic comp_mode,
    // Read data and alert pin
    output logic [tas_pkg::TAS_REG_W-1:0] status_rdata,
    output logic alert_n
);
    logic crc_fl, slew_st, slew_fl, high_st, low_st, high_fl, low_fl, drdy;
    logic high_armed, low_armed;
    logic next_crc_fl, next_slew_st, next_slew_fl, next_high_st, next_low_st;
    logic next_high_fl, next_low_fl, next_drdy, next_high_armed, next_low_armed;
    logic [tas_pkg::TAS_REG_W-1:0] next_status_rdata;
    logic next_alert_n;
    logic status_clr, temp_rd, above_hi, below_hi_hyst, below_lo, above_lo_hyst, slew_over;
    logic signed [TEMP_W+1:0] hi_rel, lo_rel;

    // Thresholds with two guard bits so limit +/- hysteresis cannot wrap
    assign hi_rel = (TEMP_W+2)'(high_limit) - (TEMP_W+2)'({2'b00, high_hyst});
    assign lo_rel = (TEMP_W+2)'(low_limit) + (TEMP_W+2)'({2'b00, low_hyst});
    assign above_hi = temp_value > high_limit;
    assign below_hi_hyst = (TEMP_W+2)'(temp_value) < hi_rel;
    assign below_lo = temp_value < low_limit;
    assign above_lo_hyst = (TEMP_W+2)'(temp_value) > lo_rel;
    assign slew_over = (slew_value > slew_limit) && !slew_value[TEMP_W-1];
    // Burst status reads leave the read-to-clear bits untouched
    assign status_clr = reg_read && !reg_burst && reg_addr == tas_pkg::TAS_ADDR_STATUS;
    assign temp_rd = reg_read && reg_addr == tas_pkg::TAS_ADDR_TEMP;

    // Flag and status next values; a set in the clearing cycle wins
    always_comb begin
        next_crc_fl = crc_fl;
        next_slew_st = slew_st;
        next_slew_fl = slew_fl;
        next_high_st = high_st;
        next_low_st = low_st;
        next_high_fl = high_fl;
        next_low_fl = low_fl;
        next_drdy = drdy;
        next_high_armed = high_armed;
        next_low_armed = low_armed;
        if (status_clr) begin
            next_crc_fl = 1'b0;
            next_slew_fl = 1'b0;
            next_high_fl = 1'b0;
            next_low_fl = 1'b0;
            next_drdy = 1'b0;
        end
        if (temp_rd) begin
            next_drdy = 1'b0;
        end
        if (crc_write_done) begin
            next_crc_fl = !crc_write_ok;
        end
        if (conv_done) begin
            next_drdy = 1'b1;
            next_slew_st = slew_over;
            if (slew_over && !slew_st) begin
                next_slew_fl = 1'b1;
            end
            if (above_hi) begin
                next_high_st = 1'b1;
            end else if (below_hi_hyst) begin
                next_high_st = 1'b0;
            end
            if (below_lo) begin
                next_low_st = 1'b1;
            end else if (above_lo_hyst) begin
                next_low_st = 1'b0;
            end
            // Upward crossing only counts while armed
            if (above_hi && high_armed) begin
                next_high_fl = 1'b1;
                next_high_armed = 1'b0;
            end else if (below_hi_hyst && !high_armed) begin
                next_high_fl = 1'b1;
                next_high_armed = 1'b1;
            end
            if (below_lo && low_armed) begin
                next_low_fl = 1'b1;
                next_low_armed = 1'b0;
            end else if (above_lo_hyst && !low_armed) begin
                next_low_fl = 1'b1;
                next_low_armed = 1'b1;
            end
        end
    end

    // Read image and alert; upper byte is constant zero
    always_comb begin
        next_status_rdata = tas_pkg::TAS_STATUS_RESET;
        next_status_rdata[tas_pkg::TAS_BIT_CRC] = next_crc_fl;
        next_status_rdata[tas_pkg::TAS_BIT_SLEW_ST] = next_slew_st;
        next_status_rdata[tas_pkg::TAS_BIT_SLEW_FL] = next_slew_fl;
        next_status_rdata[tas_pkg::TAS_BIT_HIGH_ST] = next_high_st;
        next_status_rdata[tas_pkg::TAS_BIT_LOW_ST] = next_low_st;
        next_status_rdata[tas_pkg::TAS_BIT_HIGH_FL] = next_high_fl;
        next_status_rdata[tas_pkg::TAS_BIT_LOW_FL] = next_low_fl;
        next_status_rdata[tas_pkg::TAS_BIT_DRDY] = next_drdy;
        // Comparator mode drives the pin from live high/slew status only
        if (comp_mode) begin
            next_alert_n = !((alert_enable[tas_pkg::TAS_EN_HIGH] && next_high_st) ||
                             (alert_enable[tas_pkg::TAS_EN_SLEW] && next_slew_st));
        end else begin
            next_alert_n = !((alert_enable[tas_pkg::TAS_EN_HIGH] && next_high_fl) ||
                             (alert_enable[tas_pkg::TAS_EN_SLEW] && next_slew_fl) ||
                             (alert_enable[tas_pkg::TAS_EN_LOW] && next_low_fl) ||
                             (alert_enable[tas_pkg::TAS_EN_CRC] && next_crc_fl) ||
                             (alert_enable[tas_pkg::TAS_EN_DRDY] && next_drdy));
        end
    end

    // State registers; flags cleared, arm bits and alert pin set at reset
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            crc_fl <= 1'b0;
            slew_st <= 1'b0;
            slew_fl <= 1'b0;
            high_st <= 1'b0;
            low_st <= 1'b0;
            high_fl <= 1'b0;
            low_fl <= 1'b0;
            drdy <= 1'b0;
            high_armed <= 1'b1;
            low_armed <= 1'b1;
            status_rdata <= tas_pkg::TAS_STATUS_RESET;
            alert_n <= 1'b1;
        end else begin
            crc_fl <= next_crc_fl;
            slew_st <= next_slew_st;
            slew_fl <= next_slew_fl;
            high_st <= next_high_st;
            low_st <= next_low_st;
            high_fl <= next_high_fl;
            low_fl <= next_low_fl;
            drdy <= next_drdy;
            high_armed <= next_high_armed;
            low_armed <= next_low_armed;
            status_rdata <= next_status_rdata;
            alert_n <= next_alert_n;
        end
    end
endmodule

`default_nettype wire

// ### tb/tas_status_props.sv
// Checker: timing relations at the alert status block's ports.
// Assumes it is bound to tas_alert_status and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module tas_status_props #(parameter int TEMP_W = 14) (
    // Clock, reset, strobes and pin
    input wire logic mclk, rstn, conv_done, crc_write_done, crc_write_ok,
    input wire logic reg_read, reg_burst, comp_mode, alert_n,
    // Levels and read image
    input wire logic signed [TEMP_W-1:0] temp_value, high_limit, low_limit,
    input wire logic [7:0] reg_addr,
    input wire logic [4:0] alert_enable,
    input wire logic [15:0] status_rdata
);
    // Status reads with no setter in the same cycle, so set-wins cannot mask
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    wire logic quiet = reg_read && reg_addr == 8'h02 && !conv_done && !crc_write_done;
    a_rsvd_zero: assert property (status_rdata[15:8] == 8'h00) else $error("upper byte");
    a_drdy_set: assert property (conv_done |=> status_rdata[0]) else $error("ready lost");
    a_rc_clear: assert property (quiet && !reg_burst |=> (status_rdata & 16'h00A7) == 16'h0000)
        else $error("flag kept");
    a_burst_keep: assert property (quiet && reg_burst |=> $stable(status_rdata))
        else $error("burst cleared");
    a_crc_flag: assert property (crc_write_done |=> status_rdata[7] == !$past(crc_write_ok))
        else $error("crc flag");
    a_high_live: assert property (conv_done && temp_value > high_limit |=> status_rdata[4])
        else $error("high status");
    a_low_live: assert property (conv_done && temp_value < low_limit |=> status_rdata[3])
        else $error("low status");
    a_slew_flag: assert property ($rose(status_rdata[6]) |-> status_rdata[5]) else $error("slew");
    a_alert_pin: assert property ($stable(alert_enable) && $stable(comp_mode) |-> alert_n ==
        !(comp_mode ? |(alert_enable[3:2] & {status_rdata[6], status_rdata[4]})
        : |(alert_enable & {status_rdata[7], status_rdata[5], status_rdata[2:0]})))
        else $error("alert pin");
endmodule
`default_nettype wire

// ### tb/tas_host_model.sv
// Host model: register reads as the serial front end presents them.
// Assumes strobes move on the falling edge of mclk.
`timescale 1ns/1ps
`default_nettype none
module tas_host_model (
    // Clock and read image
    input wire logic mclk,
    input wire logic [15:0] status_rdata,
    // Read request
    output logic reg_read = 1'b0,
    output logic [7:0] reg_addr = 8'hFF,
    output logic reg_burst = 1'b0
);
    // One read; image is taken before its clear lands
    task automatic rd(input logic [7:0] a, input logic b, output logic [15:0] d);
        @(negedge mclk);
        {reg_read, reg_addr, reg_burst} = {1'b1, a, b};
        d = status_rdata;
        @(negedge mclk);
        {reg_read, reg_addr} = {1'b0, ~a}; // Idle address never repeats the last one
    endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Bench: conversion table through the alert status block, then edge cases.
// Assumes the host model for reads; checker bound at the foot.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk = 1'b0, rstn = 1'b0, conv_done = 1'b0, crc_write_done = 1'b0;
    logic crc_write_ok = 1'b0, comp_mode = 1'b0, alert_n, reg_read, reg_burst;
    logic signed [13:0] temp_value = '0, slew_value = '0, high_limit = 14'h0064;
    logic signed [13:0] low_limit = 14'h3F9C, slew_limit = 14'h0032;
    logic [13:0] high_hyst = 14'h000A, low_hyst = 14'h000A;
    logic [4:0] alert_enable = 5'h1F;
    logic [7:0] reg_addr;
    logic [15:0] status_rdata, d;
    int n_errors = 0, total_checks = 0, cycles = 0;
    // Temperature, slew, expected flags; limits 100/-100, hysteresis 10, slew 50
    logic [31:0] rows [11] = '{32'h00000001, 32'h00783C75, 32'h005F3C51, 32'h00780011,
        32'h00500005, 32'h00780015, 32'h00000005, 32'hFF88000B, 32'hFFA10009,
        32'hFFB00003, 32'hFF88000B};
    tas_alert_status #(.TEMP_W(14)) DUT (.*);
    tas_host_model host (.*);
    initial forever #10 mclk = ~mclk;
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Hang guard: the run needs about 90 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One conversion (cv=1) or one checksum write outcome (cv=0)
    task automatic pulse(input logic cv, input logic [13:0] t, s, input logic ok);
        @(negedge mclk);
        {conv_done, crc_write_done, temp_value, slew_value, crc_write_ok} = {cv, !cv, t, s, ok};
        @(negedge mclk);
        {conv_done, crc_write_done} = 2'b00;
    endtask
    initial begin
        repeat (16) @(negedge mclk);
        chk("reset image", status_rdata, 16'h0000);
        chk("reset pin", {15'h0000, alert_n}, 16'h0001);
        rstn = 1'b1;
        foreach (rows[i]) begin
            pulse(1'b1, rows[i][29:16], {6'h00, rows[i][15:8]}, 1'b0);
            host.rd(8'h02, 1'b0, d);
            chk("status row", d, {8'h00, rows[i][7:0]});
        end
        // Burst read must leave flags; temperature read clears ready only
        pulse(1'b1, 14'h0000, 14'h0000, 1'b0);
        host.rd(8'h02, 1'b1, d);
        host.rd(8'h02, 1'b0, d);
        chk("after burst", d, 16'h0003);
        pulse(1'b1, 14'h0000, 14'h0000, 1'b0);
        host.rd(8'h00, 1'b0, d);
        host.rd(8'h02, 1'b0, d);
        chk("temp read", d, 16'h0000);
        // Masked checksum failure still recorded
        alert_enable = 5'h0F;
        pulse(1'b0, 14'h0000, 14'h0000, 1'b0);
        chk("masked pin", {15'h0000, alert_n}, 16'h0001);
        host.rd(8'h02, 1'b0, d);
        chk("masked flag", d, 16'h0080);
        alert_enable = 5'h1F;
        pulse(1'b0, 14'h0000, 14'h0000, 1'b0);
        chk("crc pin", {15'h0000, alert_n}, 16'h0000);
        pulse(1'b0, 14'h0000, 14'h0000, 1'b1);
        host.rd(8'h02, 1'b0, d);
        chk("good write", d, 16'h0000);
        // Comparator mode follows live status, not sticky flags
        comp_mode = 1'b1;
        pulse(1'b1, 14'h0078, 14'h0000, 1'b0);
        host.rd(8'h02, 1'b0, d);
        chk("live pin", {15'h0000, alert_n}, 16'h0000);
        pulse(1'b1, 14'h0050, 14'h0000, 1'b0);
        chk("flag ignored", {15'h0000, alert_n}, 16'h0001);
        tally_and_finish();
    end
endmodule
bind tas_alert_status tas_status_props #(.TEMP_W(TEMP_W)) u_props (.*);
`default_nettype wire
